//--- rx_seq_cfg.svh
// constants for the receiver power step sequencer
`ifndef RX_SEQ_CFG_SVH
`define RX_SEQ_CFG_SVH
`define CLK_FREQ_MHZ 25
`define STEP_TIME_US 625
`define STEP_CYCLES (`CLK_FREQ_MHZ * `STEP_TIME_US)
`define UNIT_TIME_MS 80
`define UNIT_STEPS ((`UNIT_TIME_MS * 1000) / `STEP_TIME_US)
`define HUNT_SEL1_MIN 1
`define HUNT_SEL0_MIN 4
`define HUNT_SEL1_STEPS ((`HUNT_SEL1_MIN * 60000000) / `STEP_TIME_US)
`define HUNT_SEL0_STEPS ((`HUNT_SEL0_MIN * 60000000) / `STEP_TIME_US)
`define PROBE_DEFAULT_MS 1500
`define PROBE_DEFAULT_STEPS ((`PROBE_DEFAULT_MS * 1000) / `STEP_TIME_US)
`define TMR_W 19
`define PKT_ID_TIMING 8'h06
`define PKT_ID_OVERRIDE 8'h0F
`define PKT_ID_OFF 8'h10
`define PKT_ID_WARM_TOP 5'h02
`define ID_HI 31
`define ID_LO 24
`define ID_TOP_HI 31
`define ID_TOP_LO 27
`define SET_HI 26
`define SET_LO 24
`define B1_HI 15
`define B1_LO 8
`define B0_HI 7
`define B0_LO 0
`define WARM_ST_HI 6
`define SE_BIT 23
`define LBC_BIT 19
`define PHASE_OFF 3'h0
`define PHASE_FIRST 3'h1
`define PHASE_LAST 3'h5
`define DWELL_RST 8'h01
`define BYTE_RST 8'h00
`define LINES_HIZ 8'h00
`define LINES_DRIVE 8'hFF
`endif

//--- rx_seq_pkg.sv
// types shared by the receiver power step sequencer
package rx_seq_pkg;
  // sequencer walk: idle (receiver off), running a phase, holding last pattern
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HOLD} seq_state_t;
  typedef logic [7:0] line_t;
endpackage : rx_seq_pkg

//--- step_timer.sv
// down counter in 625 us steps with its own restartable prescaler
`include "rx_seq_cfg.svh"
module step_timer #(
  parameter int W = `TMR_W,
  parameter int PRE = `STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic load_i, // restart with value_i
  input wire logic [W-1:0] value_i,
  input wire logic stop_i, // abandon the count
  output logic expire_o, // one-cycle pulse at the end
  output logic run_o // count in progress
);
  logic [W-1:0] cnt; // steps left
  logic [31:0] pre; // cycles within the current step
  wire step_end = (pre == 32'(PRE - 1));
  wire last_step = (cnt <= W'(1));

  // prescaler restarts on load so each step is a full 625 us
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt <= '0;
      pre <= '0;
      run_o <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (load_i) begin
        cnt <= value_i;
        pre <= '0;
        run_o <= 1'b1;
      end else if (stop_i) begin
        run_o <= 1'b0;
      end else if (run_o && step_end) begin
        pre <= '0;
        cnt <= last_step ? '0 : cnt - W'(1);
        run_o <= !last_step;
        expire_o <= last_step; // zero count ends after one step
      end else if (run_o) begin
        pre <= pre + 32'd1;
      end
    end
  end
endmodule : step_timer

//--- rx_power_step_sequencer.sv
// receiver control line sequencer, override and asynchronous timing settings
// Contract
// - timing packet id 6 carries both bytes
// - hunt time is field times 80 ms
// - zero field gives one or four minutes
// - probe spacing is field times 80 ms
// - zero probe field gives 1.5 seconds
// - override packet id 15, mask and pattern
// - control lines float while in reset
// - masked lines take the forced pattern bit
// - unmasked lines follow the sequencer
// - twelve settings at packet ids 16-27
// - probe bit samples battery on leaving
// - active phase drives its line pattern
// - off phase dwells before first warm-up
// - low id bits select warm-up 1-5
// - disabled warm-up ends the walk there
// - warm-up dwell is 7-bit step count
// - dwell counts reset to one step
// - hunt timeout returns to periodic probes
`include "rx_seq_cfg.svh"
module rx_power_step_sequencer #(
  parameter int step_cycles = `STEP_CYCLES // cycles per 625 us step
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pkt_valid_i,
  input wire logic [31:0] pkt_word_i,
  input wire logic warmup_req_i,
  input wire logic power_down_i,
  input wire logic low_battery_input_i,
  input wire logic async_mode_i,
  input wire logic long_hunt_i,
  input wire logic hunt_start_i,
  input wire logic hunt_found_i,
  output rx_seq_pkg::line_t rx_ctrl_lines_o,
  output rx_seq_pkg::line_t rx_ctrl_oe_o,
  output logic [2:0] phase_o,
  output logic seq_busy_o,
  output logic seq_ready_o,
  output logic battery_low_o,
  output logic battery_sample_o,
  output logic noise_detect_start_o,
  output logic hunt_active_o,
  output logic hunt_timeout_o
);
  import rx_seq_pkg::*;

  // packet fields
  wire [7:0] pkt_id = pkt_word_i[`ID_HI:`ID_LO];
  wire [7:0] pkt_b1 = pkt_word_i[`B1_HI:`B1_LO];
  wire [7:0] pkt_b0 = pkt_word_i[`B0_HI:`B0_LO];
  wire [2:0] pkt_set = pkt_word_i[`SET_HI:`SET_LO];
  wire wr_timing = pkt_valid_i && (pkt_id == `PKT_ID_TIMING);
  wire wr_override = pkt_valid_i && (pkt_id == `PKT_ID_OVERRIDE);
  wire wr_off = pkt_valid_i && (pkt_id == `PKT_ID_OFF);
  // warm-up ids 17..21; ids 22..27 belong to other settings and are ignored here
  wire wr_warm = pkt_valid_i && (pkt_word_i[`ID_TOP_HI:`ID_TOP_LO] == `PKT_ID_WARM_TOP)
    && (pkt_set >= `PHASE_FIRST) && (pkt_set <= `PHASE_LAST);

  // stored settings
  logic [7:0] sync_hunt_timeout; // hunt length in 80 ms units
  logic [7:0] idle_probe_period; // probe spacing in 80 ms units
  line_t line_override_mask; // one per forced line
  line_t forced_pattern; // value for forced lines
  line_t line_pattern [0:5]; // phase 0 is the off phase
  logic [7:0] dwell_count [0:5]; // steps per phase
  logic [5:0] battery_probe; // sample battery on leaving
  logic [5:0] step_enable; // bit 0 unused, off phase always runs

  // packet writes
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync_hunt_timeout <= `BYTE_RST;
      idle_probe_period <= `BYTE_RST;
      line_override_mask <= `BYTE_RST;
      forced_pattern <= `BYTE_RST;
    end else if (wr_timing) begin
      sync_hunt_timeout <= pkt_b1;
      idle_probe_period <= pkt_b0;
    end else if (wr_override) begin
      line_override_mask <= pkt_b1;
      forced_pattern <= pkt_b0;
    end
  end

  // a line override packet replaces both bytes at once
  override_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_override |=> (line_override_mask == $past(pkt_b1)) && (forced_pattern == $past(pkt_b0)))
    else $error("override packet not stored");

  // phase setting storage, one entry per phase index
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      battery_probe <= '0;
      step_enable <= '0;
      for (int i = 0; i < 6; i++) begin
        line_pattern[i] <= `BYTE_RST;
        dwell_count[i] <= `DWELL_RST;
      end
    end else if (wr_off) begin
      line_pattern[`PHASE_OFF] <= pkt_b1;
      dwell_count[`PHASE_OFF] <= pkt_b0;
      battery_probe[`PHASE_OFF] <= pkt_word_i[`LBC_BIT];
    end else if (wr_warm) begin
      line_pattern[pkt_set] <= pkt_b1;
      dwell_count[pkt_set] <= {1'b0, pkt_word_i[`WARM_ST_HI:`B0_LO]};
      battery_probe[pkt_set] <= pkt_word_i[`LBC_BIT];
      step_enable[pkt_set] <= pkt_word_i[`SE_BIT];
    end
  end

  // off packet takes the full byte as its dwell
  off_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_off |=> (dwell_count[`PHASE_OFF] == $past(pkt_b0)) && (line_pattern[`PHASE_OFF] == $past(pkt_b1)))
    else $error("off packet not stored");
  // warm-up dwell keeps only seven bits, top bit clear
  warm_dwell_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_warm |=> (dwell_count[$past(pkt_set)] == {1'b0, $past(pkt_word_i[`WARM_ST_HI:`B0_LO])})
      && (line_pattern[$past(pkt_set)] == $past(pkt_b1))) else $error("warm-up packet not stored");
  // enable bit lands in the addressed warm-up slot
  warm_enable_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_warm |=> (step_enable[$past(pkt_set)] == $past(pkt_word_i[`SE_BIT])))
    else $error("step enable not stored");

  // sequencer state
  seq_state_t state;
  seq_state_t next_state;
  logic [2:0] idx; // phase in progress, 0 = off
  logic [2:0] next_idx;
  logic dwell_load;
  logic dwell_expire;
  logic dwell_run;

  wire [2:0] idx_up = idx + `PHASE_FIRST;
  wire more_phases = (idx < `PHASE_LAST) && step_enable[idx_up];
  wire leave_phase = (state == SEQ_RUN) && (dwell_expire || power_down_i);
  wire sample_en = leave_phase && battery_probe[idx];

  // phase walk: off, then warm-ups in ascending order until the first disabled one
  always_comb begin
    next_state = state;
    next_idx = idx;
    dwell_load = 1'b0;
    case (state)
      SEQ_IDLE: begin
        if (warmup_req_i && !power_down_i) begin // start with the off phase
          next_state = SEQ_RUN;
          next_idx = `PHASE_OFF;
          dwell_load = 1'b1;
        end
      end
      SEQ_RUN: begin
        if (power_down_i) begin // abandon the walk
          next_state = SEQ_IDLE;
          next_idx = `PHASE_OFF;
        end else if (dwell_expire && more_phases) begin
          next_idx = idx_up;
          dwell_load = 1'b1;
        end else if (dwell_expire) begin
          next_state = SEQ_HOLD;
        end
      end
      SEQ_HOLD: begin
        if (power_down_i) begin // back to receiver off
          next_state = SEQ_IDLE;
          next_idx = `PHASE_OFF;
        end
      end
      default: begin
        next_state = SEQ_IDLE;
        next_idx = `PHASE_OFF;
      end
    endcase
  end

  // dwell timer of the running phase
  step_timer #(.W(`TMR_W), .PRE(step_cycles)) dwell_timer (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .load_i(dwell_load),
    .value_i(`TMR_W'(dwell_count[next_idx])),
    .stop_i(power_down_i),
    .expire_o(dwell_expire),
    .run_o(dwell_run)
  );

  // state registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= SEQ_IDLE;
      idx <= `PHASE_OFF;
    end else begin
      state <= next_state;
      idx <= next_idx;
    end
  end

  // line selection: phase pattern then per-line override
  wire [7:0] internal_lines = line_pattern[next_idx];
  wire [7:0] next_lines = (line_override_mask & forced_pattern)
    | (~line_override_mask & internal_lines);

  // control line pins and sequencer status
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rx_ctrl_lines_o <= `LINES_HIZ;
      rx_ctrl_oe_o <= `LINES_HIZ;
      phase_o <= `PHASE_OFF;
      seq_busy_o <= 1'b0;
      seq_ready_o <= 1'b0;
      battery_low_o <= 1'b0;
      battery_sample_o <= 1'b0;
    end else begin
      rx_ctrl_lines_o <= next_lines;
      rx_ctrl_oe_o <= `LINES_DRIVE;
      phase_o <= next_idx;
      seq_busy_o <= (next_state == SEQ_RUN);
      seq_ready_o <= (next_state == SEQ_HOLD);
      battery_sample_o <= sample_en;
      if (sample_en) begin
        battery_low_o <= low_battery_input_i;
      end
    end
  end

  // outside reset every control line is driven
  lines_driven_a: assert property (@(posedge clk_i)
    rstn_i && $past(rstn_i) |-> (rx_ctrl_oe_o == `LINES_DRIVE)) else $error("control lines left floating");
  // walk status flags are never both set
  flags_apart_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !(seq_busy_o && seq_ready_o)) else $error("busy and ready together");
  // a running walk only shows off or warm-up phases
  phase_range_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    seq_busy_o |-> (phase_o <= `PHASE_LAST)) else $error("phase index out of range");
  // no battery sample from a phase without its probe bit
  quiet_probe_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !battery_probe[idx] |=> !battery_sample_o) else $error("battery sampled without probe bit");

  // asynchronous timing: hunt length and probe spacing in steps
  logic [`TMR_W-1:0] hunt_steps;
  logic [`TMR_W-1:0] probe_steps;
  assign hunt_steps = (sync_hunt_timeout != `BYTE_RST)
    ? `TMR_W'(sync_hunt_timeout * `UNIT_STEPS)
    : (long_hunt_i ? `TMR_W'(`HUNT_SEL1_STEPS) : `TMR_W'(`HUNT_SEL0_STEPS));
  assign probe_steps = (idle_probe_period != `BYTE_RST)
    ? `TMR_W'(idle_probe_period * `UNIT_STEPS)
    : `TMR_W'(`PROBE_DEFAULT_STEPS);

  logic async_seen; // async_mode_i one cycle ago
  logic probe_expire;
  logic hunt_expire;
  wire async_rise = async_mode_i && !async_seen;
  wire probe_load = async_mode_i && (async_rise || probe_expire);
  wire hunt_load = async_mode_i && hunt_start_i && !hunt_active_o;
  wire hunt_end = hunt_active_o && (hunt_found_i || !async_mode_i);

  step_timer #(.W(`TMR_W), .PRE(step_cycles)) probe_timer (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .load_i(probe_load),
    .value_i(probe_steps),
    .stop_i(!async_mode_i),
    .expire_o(probe_expire),
    .run_o()
  );

  step_timer #(.W(`TMR_W), .PRE(step_cycles)) hunt_timer (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .load_i(hunt_load),
    .value_i(hunt_steps),
    .stop_i(hunt_end),
    .expire_o(hunt_expire),
    .run_o()
  );

  // hunt has priority; probe timing keeps running through it
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      async_seen <= 1'b0;
      hunt_active_o <= 1'b0;
      hunt_timeout_o <= 1'b0;
      noise_detect_start_o <= 1'b0;
    end else begin
      async_seen <= async_mode_i;
      noise_detect_start_o <= probe_load && !hunt_active_o && !hunt_load;
      hunt_timeout_o <= hunt_active_o && hunt_expire && !hunt_end;
      if (hunt_load) begin
        hunt_active_o <= 1'b1;
      end else if (hunt_end || hunt_expire) begin
        hunt_active_o <= 1'b0;
      end
    end
  end

  // no automatic noise detect starts while a hunt runs
  hunt_mutes_probe_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    hunt_active_o |=> !noise_detect_start_o) else $error("noise detect during hunt");
  // probe timing and hunts belong to asynchronous mode only
  probe_async_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !async_mode_i |=> !noise_detect_start_o && !hunt_active_o) else $error("async timing outside async mode");
  // timeout is a single pulse that ends the hunt
  hunt_pulse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    hunt_timeout_o |=> !hunt_timeout_o) else $error("hunt timeout pulse too long");
  // first probe start follows entry to asynchronous mode
  probe_first_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    async_mode_i && !async_seen && !hunt_active_o && !hunt_load |=> noise_detect_start_o)
    else $error("no noise detect on entering async mode");

  // checks
  lines_float_a: assert property (@(posedge clk_i)
    !rstn_i |=> (rx_ctrl_oe_o == `LINES_HIZ)) else $error("control lines driven in reset");
  forced_lines_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $past(rstn_i) |-> ((rx_ctrl_lines_o & $past(line_override_mask))
      == ($past(line_override_mask) & $past(forced_pattern)))) else $error("forced line wrong");
  free_lines_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $past(rstn_i) |-> ((rx_ctrl_lines_o & ~$past(line_override_mask))
      == (~$past(line_override_mask) & $past(internal_lines)))) else $error("free line wrong");
  timing_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_timing |=> (sync_hunt_timeout == $past(pkt_b1)) && (idle_probe_period == $past(pkt_b0)))
    else $error("timing packet not stored");
  hunt_default_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (sync_hunt_timeout == `BYTE_RST) |-> (hunt_steps ==
      (long_hunt_i ? `TMR_W'(`HUNT_SEL1_STEPS) : `TMR_W'(`HUNT_SEL0_STEPS))))
    else $error("hunt default wrong");
  probe_default_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (idle_probe_period == `BYTE_RST) |-> (probe_steps == `TMR_W'(`PROBE_DEFAULT_STEPS)))
    else $error("probe default wrong");
  off_first_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == SEQ_IDLE) && warmup_req_i && !power_down_i |=> (state == SEQ_RUN) && (idx == `PHASE_OFF)
      && seq_busy_o) else $error("walk did not start in off phase");
  walk_end_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == SEQ_RUN) && dwell_expire && !power_down_i && !more_phases |=> (state == SEQ_HOLD)
      ##0 seq_ready_o) else $error("disabled warm-up not skipped");
  walk_step_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == SEQ_RUN) && dwell_expire && !power_down_i && more_phases |=> (idx == $past(idx_up))
      && dwell_run) else $error("warm-up order wrong");
  battery_take_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sample_en |=> battery_sample_o && (battery_low_o == $past(low_battery_input_i)))
    else $error("battery not sampled on leaving");
  dwell_reset_a: assert property (@(posedge clk_i)
    $past(!rstn_i) && rstn_i |-> (dwell_count[`PHASE_OFF] == `DWELL_RST)) else $error("dwell reset wrong");
  hunt_over_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    hunt_timeout_o |-> !hunt_active_o) else $error("hunt still active after timeout");
endmodule : rx_power_step_sequencer

//--- paging_rx_model.sv
// behavioural paging receiver sitting on the control lines
module paging_rx_model (
  input wire logic clk_i,
  input wire logic [7:0] lines_i,
  input wire logic [7:0] oe_i,
  input wire logic batt_weak_i, // battery state chosen by the bench
  output logic low_battery_o,
  output logic [7:0] seen_o // level the receiver sees on each line
);
  timeunit 1ns;
  timeprecision 1ns;
  // released lines settle low through the receiver's weak pull-downs
  assign seen_o = lines_i & oe_i;
  // battery comparator output follows the cell one cycle later
  always_ff @(posedge clk_i) begin
    low_battery_o <= batt_weak_i;
  end
endmodule : paging_rx_model

//--- rx_power_step_sequencer_tb.sv
// self-checking bench for the receiver power step sequencer
module rx_power_step_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rx_seq_pkg::*;
  localparam int SC = 4; // shortened step length in cycles
  logic clk_i, rstn_i, pkt_valid_i, warmup_req_i, power_down_i, async_mode_i;
  logic long_hunt_i, hunt_start_i, hunt_found_i, batt, lowb;
  logic [31:0] pkt_word_i;
  line_t lines, oe, seen;
  logic [2:0] phase;
  logic busy, ready, blow, bsamp, nds, hact, hto;
  int err_count, compares, seed, k, i, nsamp;
  int pat[6], dw[6], en[6], pr[6], mask, fpat; // reference model
  rx_power_step_sequencer #(.step_cycles(SC)) rx_power_step_sequencer_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .pkt_valid_i(pkt_valid_i), .pkt_word_i(pkt_word_i), .warmup_req_i(warmup_req_i), .power_down_i(power_down_i),
    .low_battery_input_i(lowb), .async_mode_i(async_mode_i), .long_hunt_i(long_hunt_i), .hunt_start_i(hunt_start_i),
    .hunt_found_i(hunt_found_i), .rx_ctrl_lines_o(lines), .rx_ctrl_oe_o(oe), .phase_o(phase), .seq_busy_o(busy),
    .seq_ready_o(ready), .battery_low_o(blow), .battery_sample_o(bsamp), .noise_detect_start_o(nds),
    .hunt_active_o(hact), .hunt_timeout_o(hto));
  paging_rx_model paging_rx_model_inst (.clk_i(clk_i), .lines_i(lines), .oe_i(oe), .batt_weak_i(batt),
    .low_battery_o(lowb), .seen_o(seen));
  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // battery sample pulses seen so far
  always @(posedge clk_i) begin
    if (bsamp === 1'b1) nsamp <= nsamp + 1;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  // a measured span must lie within two cycles of its figure
  task automatic near(input int got, input int exp);
    compares++;
    if (got < exp - 2 || got > exp + 2) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : near
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // cycles until a signal is seen high, bounded
  task automatic span(ref logic s, input int lim, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (s !== 1'b1 && n < lim);
  endtask : span
  // one packet strobe, mirrored into the model
  task automatic send(input int id, input int b2, input int b1, input int b0);
    b1 = b1 & 255;
    b0 = b0 & 255;
    @(posedge clk_i);
    pkt_valid_i <= 1'b1;
    pkt_word_i <= {id[7:0], b2[7:0], b1[7:0], b0[7:0]};
    @(posedge clk_i);
    pkt_valid_i <= 1'b0;
    if (id == 15) begin
      mask = b1;
      fpat = b0;
    end
    if (id >= 16 && id <= 21) begin
      pat[id-16] = b1;
      dw[id-16] = (id == 16) ? b0 : b0 & 127;
      pr[id-16] = b2[3];
      en[id-16] = b2[7];
    end
  endtask : send
  // expected line levels after the override
  function automatic int ex(input int s);
    return ((mask & fpat) | (~mask & s)) & 255;
  endfunction : ex
  // run one warm-up walk and follow it phase by phase
  task automatic walk(input logic b);
    int p, any, n0;
    p = 0;
    any = 0;
    n0 = nsamp;
    @(posedge clk_i);
    batt <= b;
    warmup_req_i <= 1'b1;
    @(posedge clk_i);
    warmup_req_i <= 1'b0;
    span(busy, 10, k);
    chk(busy, 1);
    forever begin
      chk(phase, p);
      chk(lines, ex(pat[p]));
      // phase 0 is first looked at one cycle after it starts
      k = (p == 0) ? 1 : 0;
      while (phase === p[2:0] && ready !== 1'b1 && k < 2000) begin
        tick(1);
        k++;
      end
      near(k, (dw[p] < 1 ? 1 : dw[p]) * SC + 1);
      any += pr[p];
      if (p == 5 || en[p+1] == 0) break;
      p++;
    end
    chk(ready, 1);
    chk(lines, ex(pat[p]));
    if (any != 0) chk(blow, b);
    @(posedge clk_i);
    power_down_i <= 1'b1;
    tick(3);
    @(posedge clk_i);
    power_down_i <= 1'b0;
    tick(1);
    chk(busy | ready, 0);
    chk(lines, ex(pat[0]));
    chk(nsamp - n0, any);
    $display("walk done");
  endtask : walk
  // end of run
  task automatic finish_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // watchdog, about twice the expected run length
  initial begin
    #2000000;
    err_count++;
    finish_test();
  end
  // main sequence
  initial begin
    seed = 32'hbc3d2832;
    {rstn_i, pkt_valid_i, warmup_req_i, power_down_i, async_mode_i, hunt_start_i, hunt_found_i, batt} = '0;
    pkt_word_i = 32'h0;
    long_hunt_i = 1'($random(seed));
    mask = 0;
    fpat = 0;
    for (i = 0; i < 6; i++) begin
      pat[i] = 0;
      dw[i] = 1;
      en[i] = 0;
      pr[i] = 0;
    end
    tick(19);
    chk(oe, 8'h00);
    chk(seen, 8'h00);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    tick(2);
    chk(oe, 8'hFF);
    chk(lines, 8'h00);
    $display("reset test done");
    send(15, 0, 8'hFF, 8'h55);
    tick(1);
    chk(seen, ex(0));
    send(15, 0, 8'h0F, 8'hA5);
    tick(1);
    chk(lines, ex(0));
    send(15, 0, 0, 0);
    $display("override test done");
    // settings only change while the walk is idle
    send(17, 8'h88, $random(seed), 3);
    walk(1'b1);
    for (i = 16; i < 22; i++) begin
      send(i, (i == 21 ? 0 : 8'h80) | ((i & 1) << 3), $random(seed), 1 + ($random(seed) & 7));
    end
    walk(1'b0);
    send(18, 0, 8'h44, 2);
    send(15, 0, 8'hF0, 8'h90);
    walk(1'b1);
    send(15, 0, 0, 0);
    // period 5 keeps above the 320 ms floor
    send(6, 0, 0, 5);
    @(posedge clk_i);
    async_mode_i <= 1'b1;
    span(nds, 20, k);
    span(nds, 12000, k);
    near(k, 5 * 128 * SC);
    send(6, 0, 0, 0);
    span(nds, 12000, k);
    span(nds, 12000, k);
    near(k, 2400 * SC);
    send(6, 0, 1, 0);
    @(posedge clk_i);
    hunt_start_i <= 1'b1;
    @(posedge clk_i);
    hunt_start_i <= 1'b0;
    tick(1);
    chk(hact, 1);
    span(hto, 2000, k);
    near(k, 128 * SC + 1);
    span(nds, 12000, k);
    chk(nds, 1);
    chk(hact, 0);
    @(posedge clk_i);
    hunt_start_i <= 1'b1;
    @(posedge clk_i);
    hunt_start_i <= 1'b0;
    hunt_found_i <= 1'b1;
    tick(3);
    chk(hact | hto, 0);
    $display("async test done");
    finish_test();
  end
endmodule : rx_power_step_sequencer_tb
